// ===== hdl/cmp_ctrl.sv
// Purpose: digital control of two analog comparators, Wishbone slave
// Assumes: i_raw_cmp and the timer-one clock are synchronous to i_ref_clk
// Notes: all outputs registered; pin output enable is active low
`timescale 1ns/10ps
`include "cmp_ctrl_params.svh"
module cmp_ctrl
  import cmp_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [1:0] i_raw_cmp,
  input wire logic i_t1_clk_post,
  output ana_ctrl_s [1:0] o_ana,
  output logic [1:0] o_gate,
  output logic [1:0] o_shutdown,
  output logic [1:0] o_pin_out,
  output logic [1:0] o_pin_oe_n,
  output logic [1:0] o_event_flag
);
  state_s s_r;
  state_s s_nxt;

  function automatic logic [3:0] pos_route(input logic [1:0] sel,
                                           input int idx,
                                           input logic on);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      2'h0: r = `ROUTE_PIN;
      2'h1: r = `ROUTE_DAC;
      2'h2: r = `ROUTE_FVR;
      2'h3: r = (idx == 0) ? `ROUTE_PIN : `ROUTE_GND;
      default: r = 4'h0;
    endcase
    pos_route = on ? r : 4'h0;
  endfunction

  function automatic logic [3:0] neg_route(input logic [1:0] sel,
                                           input logic on);
    logic [3:0] r;
    r = 4'h1 << sel;
    neg_route = on ? r : 4'h0;
  endfunction

  function automatic logic [7:0] ctrl_a_byte(input cfg_a_s c,
                                             input logic res);
    logic [7:0] b;
    b = 8'h00;
    b[`BIT_ON] = c.on;
    b[`BIT_OUT] = res;
    b[`BIT_OE] = c.oe;
    b[`BIT_POL] = c.pol;
    b[`BIT_SP] = c.sp;
    b[`BIT_HYS] = c.hys;
    b[`BIT_SYNC] = c.sync;
    ctrl_a_byte = b;
  endfunction

  function automatic logic [7:0] ctrl_b_byte(input cfg_b_s c);
    logic [7:0] b;
    b = 8'h00;
    b[`BIT_RISE] = c.rise;
    b[`BIT_FALL] = c.fall;
    b[`BIT_PSEL_HI:`BIT_PSEL_LO] = c.psel;
    b[`BIT_NSEL_HI:`BIT_NSEL_LO] = c.nsel;
    ctrl_b_byte = b;
  endfunction

  logic req;
  logic wr;
  logic t1_fall;
  logic [1:0] pol_res;
  logic [1:0] ext_res;
  logic [1:0] rise_ev;
  logic [1:0] fall_ev;
  logic [7:0] wbyte;

  always_comb begin
    req = i_wb_cyc && i_wb_stb && !s_r.ack;
    wr = req && i_wb_we && i_wb_sel[0];
    wbyte = i_wb_dat[7:0];
    // prescaled timer clock, so divided captures follow the prescaler
    t1_fall = s_r.t1_prev && !i_t1_clk_post;
    for (int i = 0; i < 2; i++) begin
      // off forces raw low, so on/off and invert toggles still edge
      pol_res[i] = (s_r.cfg_a[i].on & i_raw_cmp[i])
                   ^ s_r.cfg_a[i].pol;
      ext_res[i] = s_r.cfg_a[i].sync ? s_r.sync_res[i]
                                     : pol_res[i];
      rise_ev[i] = s_r.res[i] && !s_r.prev[i];
      fall_ev[i] = !s_r.res[i] && s_r.prev[i];
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.t1_prev = i_t1_clk_post;
    for (int i = 0; i < 2; i++) begin
      s_nxt.res[i] = pol_res[i];
      s_nxt.prev[i] = s_r.res[i];
      if (t1_fall) begin
        s_nxt.sync_res[i] = pol_res[i];
      end
      s_nxt.gate[i] = ext_res[i];
      // override holds whatever comparator_on says; off drives zero
      s_nxt.pin_out[i] = s_r.cfg_a[i].oe
                         ? (s_r.cfg_a[i].on & ext_res[i])
                         : s_r.latch[i];
      s_nxt.pin_oe_n[i] = s_r.dir[i];
      s_nxt.ana[i].enable = s_r.cfg_a[i].on;
      s_nxt.ana[i].speed = s_r.cfg_a[i].sp;
      s_nxt.ana[i].hyst = s_r.cfg_a[i].hys;
      s_nxt.ana[i].pos_route = pos_route(s_r.cfg_b[i].psel, i,
                                         s_r.cfg_a[i].on);
      s_nxt.ana[i].neg_route = neg_route(s_r.cfg_b[i].nsel,
                                         s_r.cfg_a[i].on);
    end
    s_nxt.ack = req;
    s_nxt.dat = 32'h0000_0000;
    if (req && !i_wb_we) begin
      case (i_wb_adr)
        `OFS_CTRL_A0: s_nxt.dat[7:0] = ctrl_a_byte(s_r.cfg_a[0],
                                                   s_r.res[0]);
        `OFS_CTRL_A1: s_nxt.dat[7:0] = ctrl_a_byte(s_r.cfg_a[1],
                                                   s_r.res[1]);
        `OFS_CTRL_B0: s_nxt.dat[7:0] = ctrl_b_byte(s_r.cfg_b[0]);
        `OFS_CTRL_B1: s_nxt.dat[7:0] = ctrl_b_byte(s_r.cfg_b[1]);
        `OFS_MIRROR: s_nxt.dat[1:0] = s_r.res;
        `OFS_FLAG: s_nxt.dat[1:0] = s_r.flag;
        `OFS_PIN: begin
          s_nxt.dat[`BIT_DIR_LO+:2] = s_r.dir;
          s_nxt.dat[`BIT_LAT_LO+:2] = s_r.latch;
        end
        default: s_nxt.dat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (i_wb_adr)
        `OFS_CTRL_A0, `OFS_CTRL_A1: begin
          s_nxt.cfg_a[i_wb_adr[2]].on = wbyte[`BIT_ON];
          s_nxt.cfg_a[i_wb_adr[2]].oe = wbyte[`BIT_OE];
          s_nxt.cfg_a[i_wb_adr[2]].pol = wbyte[`BIT_POL];
          s_nxt.cfg_a[i_wb_adr[2]].sp = wbyte[`BIT_SP];
          s_nxt.cfg_a[i_wb_adr[2]].hys = wbyte[`BIT_HYS];
          s_nxt.cfg_a[i_wb_adr[2]].sync = wbyte[`BIT_SYNC];
        end
        `OFS_CTRL_B0, `OFS_CTRL_B1: begin
          s_nxt.cfg_b[i_wb_adr[2]].rise = wbyte[`BIT_RISE];
          s_nxt.cfg_b[i_wb_adr[2]].fall = wbyte[`BIT_FALL];
          s_nxt.cfg_b[i_wb_adr[2]].psel =
            wbyte[`BIT_PSEL_HI:`BIT_PSEL_LO];
          s_nxt.cfg_b[i_wb_adr[2]].nsel =
            wbyte[`BIT_NSEL_HI:`BIT_NSEL_LO];
        end
        // writing zero clears a flag, writing one leaves it
        `OFS_FLAG: s_nxt.flag = s_r.flag & wbyte[1:0];
        `OFS_PIN: begin
          s_nxt.dir = wbyte[`BIT_DIR_LO+:2];
          s_nxt.latch = wbyte[`BIT_LAT_LO+:2];
        end
        default: s_nxt.flag = s_nxt.flag;
      endcase
    end
    // set after the clear, so an edge during the write is kept
    for (int i = 0; i < 2; i++) begin
      if ((rise_ev[i] && s_r.cfg_b[i].rise) ||
          (fall_ev[i] && s_r.cfg_b[i].fall)) begin
        s_nxt.flag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_r <= '0;
      for (int i = 0; i < 2; i++) begin
        s_r.cfg_a[i].sp <= `RST_SP;
        s_r.ana[i].speed <= `RST_SP;
      end
      s_r.dir <= `RST_DIR;
      s_r.pin_oe_n <= `RST_DIR;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    o_wb_dat = s_r.dat;
    o_wb_ack = s_r.ack;
    o_ana = s_r.ana;
    o_gate = s_r.gate;
    o_shutdown = s_r.gate;
    o_pin_out = s_r.pin_out;
    o_pin_oe_n = s_r.pin_oe_n;
    o_event_flag = s_r.flag;
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  property p_res_follows;
    s_r.cfg_a[0].on && !s_r.cfg_a[0].sync && $stable(s_r.cfg_a[0])
      |=> s_r.res[0] == ($past(i_raw_cmp[0]) ^ $past(s_r.cfg_a[0].pol));
  endproperty
  a_res_follows: assert property (p_res_follows)
    else $error("result does not follow raw and polarity");

  property p_off_route;
    !s_r.cfg_a[1].on ##1 !s_r.cfg_a[1].on |->
      s_r.ana[1].pos_route == 4'h0 && s_r.ana[1].neg_route == 4'h0;
  endproperty
  a_off_route: assert property (p_off_route)
    else $error("inputs connected while comparator off");

  property p_code3;
    s_r.cfg_a[1].on && s_r.cfg_b[1].psel == 2'h3 ##1 s_r.cfg_a[1].on
      && s_r.cfg_b[1].psel == 2'h3 |-> s_r.ana[1].pos_route == 4'h8;
  endproperty
  a_code3: assert property (p_code3)
    else $error("second comparator code three not ground");

  property p_rise_flag;
    s_r.res[0] && !s_r.prev[0] && s_r.cfg_b[0].rise |=> s_r.flag[0];
  endproperty
  a_rise_flag: assert property (p_rise_flag)
    else $error("rising edge did not set flag");

  property p_flag_hold;
    s_r.flag[0] && !(wr && i_wb_adr == 8'h14) |=> s_r.flag[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag lost without software write");

  property p_pin_drive;
    s_r.cfg_a[0].oe && !s_r.cfg_a[0].on |=> !o_pin_out[0];
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("result on pin while comparator off");

  property p_override;
    !s_r.cfg_a[1].oe |=> o_pin_out[1] == $past(s_r.latch[1]);
  endproperty
  a_override: assert property (p_override)
    else $error("pin does not show latch without override");

  property p_sync_hold;
    s_r.cfg_a[0].sync && !t1_fall |=> $stable(s_r.sync_res[0]);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("sync result changed without timer fall");

  property p_mirror;
    req && !i_wb_we && i_wb_adr == 8'h10 |=>
      o_wb_ack && o_wb_dat[1:0] == $past(s_r.res) ##1 !o_wb_ack;
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror read wrong or ack not one cycle");

  property p_enable_follows;
    1'b1 |=> o_ana[0].enable == $past(s_r.cfg_a[0].on);
  endproperty
  a_enable_follows: assert property (p_enable_follows)
    else $error("analog enable does not follow comparator_on");

  property p_speed_follows;
    1'b1 |=> o_ana[1].speed == $past(s_r.cfg_a[1].sp);
  endproperty
  a_speed_follows: assert property (p_speed_follows)
    else $error("speed select not passed to analog side");

  property p_hyst_follows;
    1'b1 |=> o_ana[0].hyst == $past(s_r.cfg_a[0].hys);
  endproperty
  a_hyst_follows: assert property (p_hyst_follows)
    else $error("hysteresis enable not passed to analog side");

  property p_neg_route;
    s_r.cfg_a[0].on |=>
      o_ana[0].neg_route == (4'h1 << $past(s_r.cfg_b[0].nsel));
  endproperty
  a_neg_route: assert property (p_neg_route)
    else $error("negative input route does not match select");

  property p_gate_async;
    !s_r.cfg_a[0].sync |=> o_gate[0] == $past(pol_res[0]);
  endproperty
  a_gate_async: assert property (p_gate_async)
    else $error("timer gate does not carry the result");

  property p_shut_same;
    !s_r.cfg_a[0].sync |=> o_shutdown[0] == s_r.res[0];
  endproperty
  a_shut_same: assert property (p_shut_same)
    else $error("shutdown and register result differ");

  property p_sync_gate;
    s_r.cfg_a[0].sync |=> o_gate[0] == $past(s_r.sync_res[0]);
  endproperty
  a_sync_gate: assert property (p_sync_gate)
    else $error("sync mode gate not from captured result");

  property p_sync_cap;
    t1_fall |=> s_r.sync_res[0] == $past(pol_res[0]);
  endproperty
  a_sync_cap: assert property (p_sync_cap)
    else $error("result not captured at timer clock fall");

  property p_pin_dir;
    1'b1 |=> o_pin_oe_n == $past(s_r.dir);
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("pin drive enable does not follow direction");

  property p_pin_result;
    s_r.cfg_a[0].oe && s_r.cfg_a[0].on && !s_r.cfg_a[0].sync |=>
      o_pin_out[0] == $past(pol_res[0]);
  endproperty
  a_pin_result: assert property (p_pin_result)
    else $error("pin override does not carry the result");

  property p_fall_flag;
    !s_r.res[0] && s_r.prev[0] && s_r.cfg_b[0].fall |=> s_r.flag[0];
  endproperty
  a_fall_flag: assert property (p_fall_flag)
    else $error("falling edge did not set flag");

  property p_no_stray;
    !s_r.flag[0] && !(rise_ev[0] && s_r.cfg_b[0].rise)
      && !(fall_ev[0] && s_r.cfg_b[0].fall) |=> !s_r.flag[0];
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("flag set without an enabled edge");

  property p_clear;
    s_r.flag[0] && wr && i_wb_adr == 8'h14 && !wbyte[0]
      && !rise_ev[0] && !fall_ev[0] |=> !s_r.flag[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("software write did not clear flag");

  c_rise: cover property (s_r.flag[0] && $rose(s_r.res[0]));
  c_sync: cover property (s_r.cfg_a[0].sync && t1_fall);
  c_clear_race: cover property (wr && i_wb_adr == 8'h14 && rise_ev[0]);
  c_fall_flag: cover property (fall_ev[0] && s_r.cfg_b[0].fall);
  c_pin_drive: cover property (s_r.cfg_a[0].oe && !s_r.dir[0]);
endmodule

// ===== include/cmp_ctrl_params.svh
// Purpose: offsets, field positions and reset values of the comparator block
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes: data in the low byte of each word, upper bits read zero
`ifndef CMP_CTRL_PARAMS_SVH
`define CMP_CTRL_PARAMS_SVH
`define OFS_CTRL_A0 8'h00
`define OFS_CTRL_A1 8'h04
`define OFS_CTRL_B0 8'h08
`define OFS_CTRL_B1 8'h0C
`define OFS_MIRROR 8'h10
`define OFS_FLAG 8'h14
`define OFS_PIN 8'h18
`define BIT_ON 7
`define BIT_OUT 6
`define BIT_OE 5
`define BIT_POL 4
`define BIT_SP 2
`define BIT_HYS 1
`define BIT_SYNC 0
`define BIT_RISE 7
`define BIT_FALL 6
`define BIT_PSEL_HI 5
`define BIT_PSEL_LO 4
`define BIT_NSEL_HI 1
`define BIT_NSEL_LO 0
`define BIT_DIR_LO 0
`define BIT_LAT_LO 4
`define RST_SP 1'b1
`define RST_DIR 2'h3
`define ROUTE_PIN 4'h1
`define ROUTE_DAC 4'h2
`define ROUTE_FVR 4'h4
`define ROUTE_GND 4'h8
`endif

// ===== include/cmp_ctrl_pkg.sv
// Purpose: types for the comparator control block
// Assumes: two comparators
// Notes: constants live in cmp_ctrl_params.svh
package cmp_ctrl_pkg;
  typedef struct packed {
    logic on;
    logic oe;
    logic pol;
    logic sp;
    logic hys;
    logic sync;
  } cfg_a_s;
  typedef struct packed {
    logic rise;
    logic fall;
    logic [1:0] psel;
    logic [1:0] nsel;
  } cfg_b_s;
  // analog-side control for one comparator
  typedef struct packed {
    logic enable;
    logic speed;
    logic hyst;
    logic [3:0] pos_route;
    logic [3:0] neg_route;
  } ana_ctrl_s;
  typedef struct packed {
    cfg_a_s [1:0] cfg_a;
    cfg_b_s [1:0] cfg_b;
    logic [1:0] res;
    logic [1:0] prev;
    logic [1:0] sync_res;
    logic t1_prev;
    logic [1:0] flag;
    logic [1:0] dir;
    logic [1:0] latch;
    logic [1:0] pin_out;
    logic [1:0] pin_oe_n;
    logic [1:0] gate;
    ana_ctrl_s [1:0] ana;
    logic ack;
    logic [31:0] dat;
  } state_s;
endpackage

// ===== dv/cmp_far_model.sv
// Purpose: analog side of both comparators
// Assumes: voltages as 8-bit codes
// Notes: off comparator or unrouted negative input floats and toggles; unrouted positive input reads zero
`timescale 1ns/10ps
module cmp_far_model
  import cmp_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire ana_ctrl_s [1:0] i_ana,
  input wire logic [1:0][7:0] i_vp,
  input wire logic [3:0][7:0] i_vn,
  output logic [1:0] o_raw
);
  localparam logic [7:0] dac_lvl = 8'h50;
  localparam logic [7:0] ref_lvl = 8'h60;
  logic [7:0] p;
  logic [7:0] n;
  initial o_raw = 2'b00;
  always @(posedge i_ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      case (i_ana[i].pos_route)
        4'h1: p = i_vp[i];
        4'h2: p = dac_lvl;
        4'h4: p = ref_lvl;
        default: p = 8'h00;
      endcase
      n = 8'h00;
      for (int k = 0; k < 4; k++) begin
        if (i_ana[i].neg_route[k]) begin
          n = i_vn[k];
        end
      end
      if (i_ana[i].enable && i_ana[i].neg_route != 4'h0) begin
        o_raw[i] <= p > n;
      end else begin
        o_raw[i] <= ~o_raw[i];
      end
    end
  end
endmodule

// ===== dv/cmp_ctrl_test.sv
// Purpose: self-checking bench for cmp_ctrl
// Assumes: result settles within three cycles
// Notes: comparator 0 carries most scenarios
`timescale 1ns/10ps
`include "cmp_ctrl_params.svh"
module cmp_ctrl_test import cmp_ctrl_pkg::*;;
  logic clk;
  logic srst;
  logic req;
  logic we;
  logic [7:0] adr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic ack;
  logic [1:0] raw;
  logic t1;
  ana_ctrl_s [1:0] ana;
  logic [1:0] gate;
  logic [1:0] shut;
  logic [1:0] pin;
  logic [1:0] oe_n;
  logic [1:0] flag;
  logic [1:0] fq;
  logic [1:0][7:0] vp;
  logic [3:0][7:0] vn;
  logic [31:0] q;
  int failures;
  int samples_checked;
  cmp_ctrl u_dut (.i_ref_clk(clk), .i_srst(srst), .i_wb_cyc(req),
    .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack), .i_raw_cmp(raw),
    .i_t1_clk_post(t1), .o_ana(ana), .o_gate(gate),
    .o_shutdown(shut), .o_pin_out(pin), .o_pin_oe_n(oe_n),
    .o_event_flag(flag));
  cmp_far_model u_far (.i_ref_clk(clk), .i_ana(ana), .i_vp(vp),
    .i_vn(vn), .o_raw(raw));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h00_0000, d};
    // pre-edge ack and data, seen before the edge updates them
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    fq = flag;
    req <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset();
    rd(`OFS_CTRL_A1, 32'h0000_0004);
    rd(8'h1C, 32'h0000_0000);
    chk(32'({oe_n, ana[0].speed}), 32'h0000_0007);
  endtask
  task automatic t_route();
    logic [3:0] ep;
    for (int c = 0; c < 2; c++) begin
      wb(1'b1, `OFS_CTRL_A0 + 8'(4 * c), 8'h82);
      for (int k = 0; k < 4; k++) begin
        ep = (k == 3 && c == 1) ? 4'h8 : 4'h1 << (k % 3);
        wb(1'b1, `OFS_CTRL_B0 + 8'(4 * c), 8'(15 * k + 3));
        tick(2);
        chk(32'({ana[c].pos_route, ana[c].neg_route}),
            32'({ep, 4'h8 >> k}));
      end
      chk(32'({ana[c].enable, ana[c].speed, ana[c].hyst}),
          32'h0000_0005);
      wb(1'b1, `OFS_CTRL_A0 + 8'(4 * c), 8'h04);
      tick(2);
      chk(32'({ana[c].enable, ana[c].pos_route, ana[c].neg_route}),
          32'h0000_0000);
    end
  endtask
  task automatic t_cmp();
    wb(1'b1, `OFS_CTRL_B0, 8'h00);
    vp[0] <= 8'hF0;
    wb(1'b1, `OFS_CTRL_A0, 8'h80);
    tick(3);
    rd(`OFS_CTRL_A0, 32'h0000_00C0);
    rd(`OFS_MIRROR, 32'h0000_0001);
    wb(1'b1, `OFS_CTRL_A0, 8'h90);
    tick(3);
    rd(`OFS_CTRL_A0, 32'h0000_0090);
    rd(`OFS_MIRROR, 32'h0000_0000);
  endtask
  task automatic t_evt();
    wb(1'b1, `OFS_CTRL_A0, 8'h80);
    wb(1'b1, `OFS_CTRL_B0, 8'h80);
    tick(3);
    wb(1'b1, `OFS_FLAG, 8'h00);
    vp[0] <= 8'h10;
    tick(4);
    chk(32'(flag), 32'h0000_0000);
    @(posedge clk) vp[0] <= 8'hF0;
    tick(8);
    chk(32'(flag), 32'h0000_0001);
    wb(1'b1, `OFS_CTRL_B0, 8'hC0);
    vp[0] <= 8'h81;
    fork
      repeat (12) @(posedge clk) vp[0] <= ~vp[0];
      begin
        // clear lands while the result is already toggling
        repeat (3) @(posedge clk);
        wb(1'b1, `OFS_FLAG, 8'h00);
      end
    join
    chk(32'(fq), 32'h0000_0001);
    tick(4);
    wb(1'b1, `OFS_CTRL_A0, 8'h00);
    tick(3);
    wb(1'b1, `OFS_FLAG, 8'h00);
    tick(3);
    chk(32'(flag), 32'h0000_0000);
    wb(1'b1, `OFS_CTRL_A0, 8'h10);
    tick(3);
    chk(32'(flag), 32'h0000_0001);
  endtask
  task automatic t_pin();
    wb(1'b1, `OFS_PIN, 8'h12);
    wb(1'b1, `OFS_CTRL_A0, 8'h80);
    tick(3);
    chk(32'({oe_n, pin}), 32'h0000_0009);
    wb(1'b1, `OFS_CTRL_A0, 8'h20);
    tick(3);
    chk(32'(pin), 32'h0000_0000);
    wb(1'b1, `OFS_CTRL_A0, 8'hB0);
    tick(3);
    chk(32'(pin), 32'h0000_0000);
    wb(1'b1, `OFS_CTRL_A0, 8'hA0);
    tick(3);
    chk(32'(pin), 32'h0000_0001);
  endtask
  task automatic t_sync();
    wb(1'b1, `OFS_CTRL_A0, 8'h81);
    vp[0] <= 8'h10;
    tick(3);
    @(posedge clk) t1 <= 1'b0;
    tick(3);
    @(posedge clk) t1 <= 1'b1;
    vp[0] <= 8'hF0;
    tick(5);
    chk(32'({gate[0], shut[0]}), 32'h0000_0000);
    @(posedge clk) t1 <= 1'b0;
    tick(3);
    chk(32'({gate[0], shut[0]}), 32'h0000_0003);
    wb(1'b1, `OFS_CTRL_A0, 8'h80);
    vp[0] <= 8'h10;
    tick(4);
    chk(32'({gate[0], shut[0]}), 32'h0000_0000);
  endtask
  task automatic stop_test();
    $display("failures=%0d samples_checked=%0d", failures,
             samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    stop_test();
  end
  initial begin
    srst = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wd = 32'h0000_0000;
    t1 = 1'b1;
    vp = 16'h0010;
    vn = 32'h0000_0080;
    failures = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_route();
    t_cmp();
    t_evt();
    t_pin();
    t_sync();
    stop_test();
  end
endmodule
